/* msq_sequencer.sv */
// sequencer for multiply, divide, register transfer and square root
`timescale 1ns/1ps
module msq_sequencer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [msq_pkg::FUNC_W-1:0] i_func,
  input wire logic [msq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [msq_pkg::ACC_W-1:0] i_acc,
  output logic o_store_rd,
  output logic [msq_pkg::ADDR_W-1:0] o_store_addr,
  input wire logic [msq_pkg::ACC_W-1:0] i_store_data,
  input wire logic i_store_ack,
  output logic o_acc_load,
  output logic [msq_pkg::ACC_W-1:0] o_acc_data,
  output logic [msq_pkg::AR_W-1:0] o_ar,
  output logic [msq_pkg::ACC_W-1:0] o_mod,
  output logic o_busy,
  output logic o_done
);
  msq_pkg::msq_state_t state_reg, state_next;
  logic [msq_pkg::FUNC_W-1:0] func_reg, func_next;
  logic [msq_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [msq_pkg::ACC_W-1:0] mod_reg, mod_next;
  logic [msq_pkg::ALU_W-1:0] hi_reg, hi_next;
  logic [msq_pkg::AR_W-1:0] ar_reg, ar_next;
  logic [msq_pkg::RAD_W-1:0] rad_reg, rad_next;
  logic [msq_pkg::MAG_W-1:0] root_reg, root_next;
  logic sign_reg, sign_next;
  logic [msq_pkg::ACC_W-1:0] acc_data_reg, acc_data_next;
  logic acc_load_reg, acc_load_next;

  logic [msq_pkg::ALU_W-1:0] alu_a, alu_b, alu_res;
  logic alu_sub, alu_carry;
  logic cnt_load, cnt_dec, cnt_last;
  logic start_ok;

  function automatic logic [msq_pkg::ALU_W-1:0] mag_ext(input logic [msq_pkg::ACC_W-1:0] w);
    mag_ext = {{(msq_pkg::ALU_W - msq_pkg::MAG_W){1'b0}}, w[msq_pkg::MAG_W-1:0]};
  endfunction

  function automatic logic is_long_code(input logic [msq_pkg::FUNC_W-1:0] f);
    is_long_code = (f >= msq_pkg::FN_MUL) && (f <= msq_pkg::FN_SQRT);
  endfunction

  msq_arith u_arith (
    .i_a(alu_a),
    .i_b(alu_b),
    .i_sub(alu_sub),
    .o_res(alu_res),
    .o_carry(alu_carry)
  );

  msq_step_cnt u_cnt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(cnt_load),
    .i_dec(cnt_dec),
    .o_last(cnt_last)
  );

  // operand steering for one iteration
  always_comb begin
    alu_a = hi_reg;
    alu_b = mag_ext(mod_reg);
    alu_sub = 1'b0;
    if (func_reg == msq_pkg::FN_DIV) begin
      alu_a = {hi_reg[msq_pkg::ALU_W-2:0], ar_reg[msq_pkg::AR_W-1]};
      alu_sub = 1'b1;
    end else if (func_reg == msq_pkg::FN_SQRT) begin
      // trial subtrahend is root followed by 01
      alu_a = {hi_reg[msq_pkg::ALU_W-3:0], rad_reg[msq_pkg::RAD_W-1 -: 2]};
      alu_b = {{(msq_pkg::ALU_W - msq_pkg::MAG_W - 2){1'b0}}, root_reg,
               msq_pkg::ROOT_TRIAL_LSB};
      alu_sub = 1'b1;
    end
  end

  assign start_ok = (state_reg == msq_pkg::ST_IDLE) && i_start && is_long_code(i_func);

  always_comb begin
    state_next = state_reg;
    func_next = func_reg;
    addr_next = addr_reg;
    mod_next = mod_reg;
    hi_next = hi_reg;
    ar_next = ar_reg;
    rad_next = rad_reg;
    root_next = root_reg;
    sign_next = sign_reg;
    acc_data_next = acc_data_reg;
    acc_load_next = 1'b0;
    cnt_load = 1'b0;
    cnt_dec = 1'b0;
    case (state_reg)
      msq_pkg::ST_IDLE: begin
        if (start_ok) begin
          func_next = i_func;
          addr_next = i_addr;
          sign_next = i_acc[msq_pkg::SIGN_BIT];
          hi_next = mag_ext(i_acc);
          cnt_load = 1'b1;
          if (i_func == msq_pkg::FN_MUL) begin
            mod_next = i_acc;
            hi_next = '0;
            state_next = msq_pkg::ST_FETCH;
          end else if (i_func == msq_pkg::FN_DIV) begin
            state_next = msq_pkg::ST_FETCH;
          end else if (i_func == msq_pkg::FN_TO_AR) begin
            ar_next = i_acc[msq_pkg::AR_W-1:0];
            state_next = msq_pkg::ST_DONE;
          end else if (i_func == msq_pkg::FN_FROM_AR) begin
            state_next = msq_pkg::ST_WRITE;
          end else begin
            // accumulator over an all-zero lower half
            hi_next = '0;
            root_next = '0;
            rad_next = {i_acc[msq_pkg::MAG_W-1:0], {msq_pkg::MAG_W{1'b0}}};
            state_next = msq_pkg::ST_CALC;
          end
        end
      end
      msq_pkg::ST_FETCH: begin
        if (i_store_ack) begin
          if (func_reg == msq_pkg::FN_MUL) begin
            ar_next = i_store_data[msq_pkg::AR_W-1:0];
            sign_next = sign_reg ^ i_store_data[msq_pkg::SIGN_BIT];
          end else begin
            mod_next = i_store_data;
            sign_next = sign_reg ^ i_store_data[msq_pkg::SIGN_BIT];
          end
          state_next = msq_pkg::ST_CALC;
        end
      end
      msq_pkg::ST_CALC: begin
        cnt_dec = 1'b1;
        if (func_reg == msq_pkg::FN_MUL) begin
          // add when multiplier digit set, then shift pair right
          if (ar_reg[0]) begin
            hi_next = alu_res >> 1;
            ar_next = {alu_res[0], ar_reg[msq_pkg::AR_W-1:1]};
          end else begin
            hi_next = hi_reg >> 1;
            ar_next = {hi_reg[0], ar_reg[msq_pkg::AR_W-1:1]};
          end
        end else if (func_reg == msq_pkg::FN_DIV) begin
          hi_next = alu_carry ? alu_res : alu_a;
          ar_next = {ar_reg[msq_pkg::AR_W-2:0], alu_carry};
        end else begin
          // failed trial is corrected by keeping old remainder
          hi_next = alu_carry ? alu_res : alu_a;
          root_next = {root_reg[msq_pkg::MAG_W-2:0], alu_carry};
          rad_next = rad_reg << 2;
        end
        if (cnt_last) begin
          state_next = msq_pkg::ST_WRITE;
        end
      end
      msq_pkg::ST_WRITE: begin
        state_next = msq_pkg::ST_DONE;
        if (func_reg == msq_pkg::FN_MUL) begin
          // high half with sign into accumulator
          acc_data_next = {sign_reg, hi_reg[msq_pkg::MAG_W-1:0]};
          acc_load_next = 1'b1;
        end else if (func_reg == msq_pkg::FN_FROM_AR) begin
          acc_data_next = {1'b0, ar_reg};
          acc_load_next = 1'b1;
        end else if (func_reg == msq_pkg::FN_SQRT) begin
          // root has as many places as operand
          acc_data_next = {1'b0, root_reg};
          acc_load_next = 1'b1;
        end
      end
      msq_pkg::ST_DONE: begin
        state_next = msq_pkg::ST_IDLE;
      end
      default: begin
        state_next = msq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= msq_pkg::ST_IDLE;
      func_reg <= '0;
      addr_reg <= '0;
      mod_reg <= '0;
      hi_reg <= '0;
      ar_reg <= '0;
      rad_reg <= '0;
      root_reg <= '0;
      sign_reg <= 1'b0;
      acc_data_reg <= '0;
      acc_load_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      func_reg <= func_next;
      addr_reg <= addr_next;
      mod_reg <= mod_next;
      hi_reg <= hi_next;
      ar_reg <= ar_next;
      rad_reg <= rad_next;
      root_reg <= root_next;
      sign_reg <= sign_next;
      acc_data_reg <= acc_data_next;
      acc_load_reg <= acc_load_next;
    end
  end

  assign o_store_rd = (state_reg == msq_pkg::ST_FETCH);
  assign o_store_addr = addr_reg;
  assign o_acc_load = acc_load_reg;
  assign o_acc_data = acc_data_reg;
  assign o_ar = ar_reg;
  assign o_mod = mod_reg;
  assign o_busy = (state_reg != msq_pkg::ST_IDLE);
  assign o_done = (state_reg == msq_pkg::ST_DONE);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_mul_start;
    start_ok && i_func == msq_pkg::FN_MUL;
  endsequence

  property p_mul_mod;
    s_mul_start |=> o_mod == $past(i_acc) && o_store_rd;
  endproperty
  a_mul_mod: assert property (p_mul_mod) else $error("multiplicand not in modifier");

  property p_mul_fetch;
    o_store_rd && i_store_ack && func_reg == msq_pkg::FN_MUL
      |=> o_ar == $past(i_store_data[msq_pkg::AR_W-1:0]) && state_reg == msq_pkg::ST_CALC;
  endproperty
  a_mul_fetch: assert property (p_mul_fetch) else $error("multiplier not in auxiliary");

  // request and address must stand until the store answers
  property p_fetch_hold;
    o_store_rd && !i_store_ack |=> o_store_rd && $stable(o_store_addr);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("store request dropped");

  property p_div_fetch;
    o_store_rd && i_store_ack && func_reg == msq_pkg::FN_DIV
      |=> o_mod == $past(i_store_data);
  endproperty
  a_div_fetch: assert property (p_div_fetch) else $error("divisor not in modifier");

  property p_div_no_acc;
    o_acc_load |-> func_reg != msq_pkg::FN_DIV && func_reg != msq_pkg::FN_TO_AR;
  endproperty
  a_div_no_acc: assert property (p_div_no_acc) else $error("accumulator loaded wrongly");

  sequence s_to_ar_done;
    o_done ##1 !o_busy;
  endsequence
  property p_to_ar;
    start_ok && i_func == msq_pkg::FN_TO_AR
      |=> o_ar == $past(i_acc[msq_pkg::AR_W-1:0]) and s_to_ar_done;
  endproperty
  a_to_ar: assert property (p_to_ar) else $error("accumulator to auxiliary failed");

  property p_from_ar;
    o_acc_load && func_reg == msq_pkg::FN_FROM_AR |-> o_acc_data == {1'b0, o_ar};
  endproperty
  a_from_ar: assert property (p_from_ar) else $error("auxiliary to accumulator wrong");

  property p_sqrt_pos;
    o_acc_load && func_reg == msq_pkg::FN_SQRT
      |-> !o_acc_data[msq_pkg::SIGN_BIT] && o_acc_data[msq_pkg::MAG_W-1:0] == root_reg;
  endproperty
  a_sqrt_pos: assert property (p_sqrt_pos) else $error("root result malformed");

  property p_calc_len;
    $rose(state_reg == msq_pkg::ST_CALC) |-> (state_reg == msq_pkg::ST_CALC) [*8]
      ##7 state_reg == msq_pkg::ST_CALC ##1 state_reg == msq_pkg::ST_WRITE;
  endproperty
  a_calc_len: assert property (p_calc_len) else $error("iteration count wrong");

  property p_mul_sign;
    o_acc_load && func_reg == msq_pkg::FN_MUL
      |-> o_acc_data == {sign_reg, hi_reg[msq_pkg::MAG_W-1:0]} && o_done;
  endproperty
  a_mul_sign: assert property (p_mul_sign) else $error("product high half wrong");

  property p_ignore;
    state_reg == msq_pkg::ST_IDLE && i_start && !is_long_code(i_func) |=> !o_busy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign code accepted");

  property p_done_pulse;
    o_done |=> !o_done && !o_busy;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
endmodule

/* msq_pkg.sv */
// constants and types for the long-arithmetic function sequencer
// Operation
// - code 16 multiplies accumulator by addressed word
// - multiply first moves accumulator into modifier
// - multiply then loads store multiplier into auxiliary
// - product built by repeated add and shift
// - product high half accumulator, low half auxiliary
// - code 17 divides accumulator:auxiliary by store word
// - divide first reads divisor into modifier
// - quotient left in auxiliary, not accumulator
// - code 18 copies accumulator into auxiliary
// - code 19 copies auxiliary into accumulator low
// - auxiliary one digit narrower, no sign
// - code 20 replaces positive fraction by root
// - root operand is accumulator over zero half
// - root uses add/subtract unit with correction
// - root keeps fraction's number of places
package msq_pkg;
  localparam int ACC_W = 16;
  localparam int MAG_W = ACC_W - 1;
  localparam int AR_W = ACC_W - 1;
  localparam int SIGN_BIT = ACC_W - 1;
  localparam int FUNC_W = 5;
  localparam int ADDR_W = 10;
  localparam int ALU_W = 20;
  localparam int CNT_W = 4;
  localparam int RAD_W = 2 * MAG_W;
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(MAG_W - 1);
  localparam logic [FUNC_W-1:0] FN_MUL = 5'h10;
  localparam logic [FUNC_W-1:0] FN_DIV = 5'h11;
  localparam logic [FUNC_W-1:0] FN_TO_AR = 5'h12;
  localparam logic [FUNC_W-1:0] FN_FROM_AR = 5'h13;
  localparam logic [FUNC_W-1:0] FN_SQRT = 5'h14;
  localparam logic [1:0] ROOT_TRIAL_LSB = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_CALC = 3'h3,
    ST_WRITE = 3'h2,
    ST_DONE = 3'h6
  } msq_state_t;
endpackage

/* msq_arith.sv */
// add/subtract unit shared by the multiply, divide and root sequences
`timescale 1ns/1ps
module msq_arith (
  input wire logic [msq_pkg::ALU_W-1:0] i_a,
  input wire logic [msq_pkg::ALU_W-1:0] i_b,
  input wire logic i_sub,
  output logic [msq_pkg::ALU_W-1:0] o_res,
  output logic o_carry
);
  logic [msq_pkg::ALU_W:0] sum;
  logic [msq_pkg::ALU_W-1:0] b_in;

  always_comb begin
    b_in = i_sub ? ~i_b : i_b;
    // carry out on subtract means a >= b (no borrow)
    sum = {1'b0, i_a} + {1'b0, b_in} + {{msq_pkg::ALU_W{1'b0}}, i_sub};
    o_res = sum[msq_pkg::ALU_W-1:0];
    o_carry = sum[msq_pkg::ALU_W];
  end
endmodule

/* msq_step_cnt.sv */
// cycle counter for the add/shift iterations
`timescale 1ns/1ps
module msq_step_cnt (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_dec,
  output logic o_last
);
  logic [msq_pkg::CNT_W-1:0] cnt_reg;
  logic [msq_pkg::CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (i_load) begin
      cnt_next = msq_pkg::STEP_LAST;
    end else if (i_dec && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_last = (cnt_reg == '0);
endmodule

/* msq_store_model.sv */
// store model answering sequencer reads after a chosen wait
`timescale 1ns/1ps
module msq_store_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic [msq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [3:0] i_wait,
  output logic [msq_pkg::ACC_W-1:0] o_data,
  output logic o_ack
);
  logic [msq_pkg::ACC_W-1:0] mem [0:(1<<msq_pkg::ADDR_W)-1];
  logic [3:0] cnt_reg;
  // data valid only with ack; toggles otherwise so a stale word never passes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      cnt_reg <= 4'h0;
      o_data <= 16'h0;
    end else if (i_rd && !o_ack && cnt_reg == i_wait) begin
      o_ack <= 1'b1;
      o_data <= mem[i_addr];
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      cnt_reg <= (i_rd && !o_ack) ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule

/* muldiv_sqrt_sequencer_tb.sv */
// self-checking bench for the long-arithmetic sequencer
`timescale 1ns/1ps
module muldiv_sqrt_sequencer_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic [4:0] i_func = 5'h0;
  logic [9:0] i_addr = 10'h0;
  logic [15:0] i_acc = 16'h0;
  logic [3:0] wait_cyc = 4'h0;
  logic o_store_rd, o_acc_load, o_busy, o_done, ack;
  logic [9:0] o_store_addr;
  logic [15:0] sdata, o_acc_data, o_mod, a, s, lo;
  logic [14:0] o_ar;
  logic [31:0] p, q, r;
  logic [4:0] bad [4] = '{5'h00, 5'h0f, 5'h15, 5'h1f};
  int miscompares = 0;
  int comparisons = 0;

  msq_sequencer DUT (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_func(i_func),
    .i_addr(i_addr), .i_acc(i_acc), .o_store_rd(o_store_rd), .o_store_addr(o_store_addr),
    .i_store_data(sdata), .i_store_ack(ack), .o_acc_load(o_acc_load),
    .o_acc_data(o_acc_data), .o_ar(o_ar), .o_mod(o_mod), .o_busy(o_busy), .o_done(o_done));
  msq_store_model st (.i_clk(i_clk), .i_rst(i_rst), .i_rd(o_store_rd),
    .i_addr(o_store_addr), .i_wait(wait_cyc), .o_data(sdata), .o_ack(ack));

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one request; returns in the cycle where done shows
  task automatic op(input logic [4:0] f, input logic [15:0] av, input logic [15:0] sv,
                    input int w, input bit hold);
    int k;
    int fc;
    int exp_k;
    logic [9:0] ad;
    ad = 10'($urandom);
    st.mem[ad] = sv;
    wait_cyc = 4'(w);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_func <= f;
    i_addr <= ad;
    i_acc <= av;
    @(posedge i_clk);
    i_start <= hold;
    i_func <= hold ? msq_pkg::FN_TO_AR : f;
    i_acc <= ~av;
    fc = 0;
    for (k = 1; k < 60; k++) begin
      if (k > 1) @(posedge i_clk) i_start <= 1'b0;
      @(negedge i_clk);
      chk(32'(o_busy), 1);
      if (o_store_rd === 1'b1) begin
        fc++;
        chk(32'(o_store_addr), 32'(ad));
      end
      if (o_done === 1'b1) break;
    end
    // store wait w gives w+2 request cycles, then 15 steps, write and done
    exp_k = (f == msq_pkg::FN_TO_AR) ? 1 : (f == msq_pkg::FN_FROM_AR) ? 2 :
            (f == msq_pkg::FN_SQRT) ? 17 : 19 + w;
    chk(fc, (f == msq_pkg::FN_MUL || f == msq_pkg::FN_DIV) ? w + 2 : 0);
    chk(k, exp_k);
  endtask

  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(62));
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk(32'({o_busy, o_done, o_acc_load}), 0);
    // multiply, full scale first; second one also sees a start while busy
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 16'hffff : 16'($urandom);
      s = (i == 0) ? 16'h7fff : 16'($urandom);
      op(msq_pkg::FN_MUL, a, s, i % 4, i == 1);
      p = a[14:0] * s[14:0];
      chk(32'(o_acc_data), 32'({a[15] ^ s[15], p[29:15]}));
      chk(32'(o_ar), 32'(p[14:0]));
      chk(32'(o_mod), 32'(a));
      chk(32'(o_acc_load), 1);
      op(msq_pkg::FN_FROM_AR, 16'($urandom), 16'h0, 0, 0);
      chk(32'(o_acc_data), 32'({1'b0, p[14:0]}));
    end
    // divide: low half via transfer, quotient read back
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 16'h7fff : 16'($urandom) | 16'h1;
      lo = 16'($urandom);
      op(msq_pkg::FN_TO_AR, lo, 16'h0, 0, 0);
      chk(32'(o_ar), 32'(lo[14:0]));
      chk(32'(o_acc_load), 0);
      a = 16'($urandom);
      a[14:0] = (i == 0) ? 15'h7ffe : 15'($urandom % s[14:0]);
      op(msq_pkg::FN_DIV, a, s, i % 3, 0);
      q = {a[14:0], lo[14:0]} / s[14:0];
      chk(32'(o_ar), q);
      chk(32'(o_acc_load), 0);
      chk(32'(o_mod), 32'(s));
      op(msq_pkg::FN_FROM_AR, 16'($urandom), 16'h0, 0, 0);
      chk(32'(o_acc_data), 32'({1'b0, q[14:0]}));
      chk(32'(o_acc_load), 1);
    end
    // square root, zero and full scale included
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h0 : (i == 1) ? 16'h7fff : 16'($urandom);
      op(msq_pkg::FN_SQRT, a, 16'h0, 0, 0);
      r = 0;
      for (int b = 14; b >= 0; b--) begin
        if ((r | (1 << b)) * (r | (1 << b)) <= {a[14:0], 15'h0}) r = r | (1 << b);
      end
      chk(32'(o_acc_data), 32'({1'b0, r[14:0]}));
      chk(32'(o_acc_load), 1);
    end
    // codes outside the set start nothing
    foreach (bad[j]) begin
      @(posedge i_clk);
      i_start <= 1'b1;
      i_func <= bad[j];
      @(posedge i_clk);
      i_start <= 1'b0;
      repeat (4) begin
        @(negedge i_clk);
        chk(32'({o_busy, o_done, o_store_rd}), 0);
      end
    end
    results();
  end
endmodule
